// File: core/apm_device.sv
// accelerometer end: register file, power mode and output data rate control
// Functional notes
// - after reset: standby, sensing off, await command
// - power_control bit 3 set enters measurement
// - power_control bit 3 clear returns to standby
// - registers writable and readable while in standby
// - host configures first, then sets measure
// - rate register bit 4 selects low power
// - code 1111 is 3200 Hz, halves per step
// - host uses low power only codes 0111-1100
// - self-test valid only with low power clear
// - standby keeps stored samples intact
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module apm_device
  import apm_pkg::*;
#(
  parameter int unsigned BASE_PERIOD = BASE_PERIOD_CYC,
  parameter int unsigned CNT_W = 32
) (
  input wire logic clk_i,
  input wire logic reset_i,
  apm_if.dev link,
  input wire logic [SAMPLE_W-1:0] sample_i,
  output logic measuring_o,
  output logic low_power_o,
  output logic [RATE_CODE_W-1:0] rate_code_o,
  output logic sample_tick_o,
  output logic [SAMPLE_W-1:0] sample_o,
  output logic self_test_ok_o
);

  // ------------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------------
  generate
    if (BASE_PERIOD < 1 || CNT_W > 63 ||
        (64'(BASE_PERIOD) << 15) >= (64'd1 << CNT_W)) begin : g_bad_param
      $error("apm_device: BASE_PERIOD or CNT_W out of range");
    end
  endgenerate

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [CNT_W-1:0] period_of(input logic [RATE_CODE_W-1:0] code);
    logic [3:0] shift;
    shift = MAX_RATE_CODE - code;
    period_of = CNT_W'(BASE_PERIOD) << shift;
  endfunction : period_of

  function automatic logic in_space(input logic [ADDR_W-1:0] a);
    in_space = (32'(a) < REG_SPACE);
  endfunction : in_space

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  apm_mode_e mode_q;
  apm_mode_e mode_d;
  logic [DATA_W-1:0] rate_q;
  logic [DATA_W-1:0] pwr_q;
  logic [DATA_W-1:0] mem_q [REG_SPACE];
  logic [SAMPLE_W-1:0] sample_q;
  logic [DATA_W-1:0] count_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic tick_q;
  logic [DATA_W-1:0] rd_data_q;

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  wire hit_rate = (link.addr == RATE_REG_ADDR);
  wire hit_pwr = (link.addr == PWR_REG_ADDR);
  wire hit_slo = (link.addr == SAMPLE_LO_ADDR);
  wire hit_shi = (link.addr == SAMPLE_HI_ADDR);
  wire hit_cnt = (link.addr == SAMPLE_CNT_ADDR);
  wire hit_ro = hit_slo | hit_shi | hit_cnt;
  wire hit_mem = in_space(link.addr) & ~hit_rate & ~hit_pwr & ~hit_ro;
  wire wr_rate = link.wr & hit_rate;
  wire wr_pwr = link.wr & hit_pwr;
  wire wr_mem = link.wr & hit_mem;
  wire [$clog2(REG_SPACE)-1:0] mem_idx = link.addr[$clog2(REG_SPACE)-1:0];
  wire wr_measure = link.wdata[MEASURE_BIT];

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  wire [DATA_W-1:0] rd_mux =
    hit_rate ? rate_q :
    hit_pwr ? pwr_q :
    hit_slo ? sample_q[DATA_W-1:0] :
    hit_shi ? sample_q[SAMPLE_W-1:DATA_W] :
    hit_cnt ? count_q :
    hit_mem ? mem_q[mem_idx] :
    8'h00;

  // ------------------------------------------------------------------
  // rate and power decode
  // ------------------------------------------------------------------
  wire [RATE_CODE_W-1:0] rate_code = rate_q[RATE_CODE_LSB +: RATE_CODE_W];
  wire low_power = rate_q[LOW_POWER_BIT];
  wire measuring = (mode_q == APM_MEASURE);
  wire sample_due = measuring & (cnt_q == '0);

  // ------------------------------------------------------------------
  // mode machine
  // ------------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      APM_STANDBY: begin
        if (wr_pwr && wr_measure) begin
          mode_d = APM_MEASURE;
        end
      end
      APM_MEASURE: begin
        if (wr_pwr && !wr_measure) begin
          mode_d = APM_STANDBY;
        end
      end
      default: begin
        mode_d = APM_STANDBY;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // output data rate timer
  // ------------------------------------------------------------------
  always_comb begin
    if (!measuring || sample_due) begin
      cnt_d = period_of(rate_code) - CNT_W'(1);
    end else begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_q <= APM_STANDBY;
      rate_q <= RATE_REG_RESET;
      pwr_q <= PWR_REG_RESET;
    end else begin
      mode_q <= mode_d;
      if (wr_rate) begin
        rate_q <= link.wdata & RATE_REG_MASK;
      end
      if (wr_pwr) begin
        pwr_q <= link.wdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_mem) begin
      mem_q[mem_idx] <= link.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= link.rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= sample_due;
    end
  end

  // sample store is left alone by standby
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sample_q <= '0;
      count_q <= 8'h00;
    end else if (sample_due) begin
      sample_q <= sample_i;
      count_q <= count_q + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign link.rdata = rd_data_q;
  assign measuring_o = measuring;
  assign low_power_o = low_power;
  assign rate_code_o = rate_code;
  assign sample_tick_o = tick_q;
  assign sample_o = sample_q;
  assign self_test_ok_o = measuring & ~low_power;

endmodule : apm_device

// File: pkg/apm_pkg.sv
// constants shared by the accelerometer power-mode end and its host end
package apm_pkg;

  // ------------------------------------------------------------------
  // link widths and device register map
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RATE_CODE_W = 4;
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned REG_SPACE = 64;

  localparam logic [ADDR_W-1:0] RATE_REG_ADDR = 8'h2C;
  localparam logic [ADDR_W-1:0] PWR_REG_ADDR = 8'h2D;
  localparam logic [ADDR_W-1:0] SAMPLE_LO_ADDR = 8'h32;
  localparam logic [ADDR_W-1:0] SAMPLE_HI_ADDR = 8'h33;
  localparam logic [ADDR_W-1:0] SAMPLE_CNT_ADDR = 8'h34;

  localparam int unsigned MEASURE_BIT = 3;
  localparam int unsigned LOW_POWER_BIT = 4;
  localparam int unsigned RATE_CODE_LSB = 0;

  localparam logic [DATA_W-1:0] RATE_REG_RESET = 8'h0A;
  localparam logic [DATA_W-1:0] PWR_REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RATE_REG_MASK = 8'h1F;
  localparam logic [DATA_W-1:0] PWR_MEASURE_CMD = 8'h08;
  localparam logic [DATA_W-1:0] PWR_STANDBY_CMD = 8'h00;

  // ------------------------------------------------------------------
  // rate codes and sample timing
  // ------------------------------------------------------------------
  localparam logic [RATE_CODE_W-1:0] MAX_RATE_CODE = 4'hF;
  localparam logic [RATE_CODE_W-1:0] LP_MIN_CODE = 4'h7;
  localparam logic [RATE_CODE_W-1:0] LP_MAX_CODE = 4'hC;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned FASTEST_RATE_HZ = 3200;
  localparam int unsigned BASE_PERIOD_CYC = CLK_HZ / FASTEST_RATE_HZ;

  // ------------------------------------------------------------------
  // host software registers
  // ------------------------------------------------------------------
  localparam int unsigned HOST_ADDR_W = 2;
  localparam logic [HOST_ADDR_W-1:0] HOST_CFG_ADDR = 2'h0;
  localparam logic [HOST_ADDR_W-1:0] HOST_CMD_ADDR = 2'h1;
  localparam logic [HOST_ADDR_W-1:0] HOST_STAT_ADDR = 2'h2;
  localparam logic [HOST_ADDR_W-1:0] HOST_RDBK_ADDR = 2'h3;
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_STOP_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_MEAS_BIT = 1;
  localparam int unsigned STAT_LPREF_BIT = 2;
  localparam logic [DATA_W-1:0] HOST_CFG_RESET = 8'h0A;

  typedef enum logic {
    APM_STANDBY = 1'b0,
    APM_MEASURE = 1'b1
  } apm_mode_e;

  typedef enum logic [2:0] {
    APM_H_IDLE = 3'h0,
    APM_H_WR_RATE = 3'h1,
    APM_H_WR_PWR = 3'h3,
    APM_H_RD_PWR = 3'h2,
    APM_H_RD_WAIT = 3'h6
  } apm_host_state_e;

endpackage : apm_pkg

// File: pkg/apm_if.sv
// register link between the host end and the accelerometer end
`timescale 1ns/10ps
interface apm_if
  import apm_pkg::*;
();
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;

  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata
  );

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata
  );
endinterface : apm_if

// File: core/apm_host.sv
// host end: sequences configuration and measurement commands over the link
`timescale 1ns/10ps
module apm_host
  import apm_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [HOST_ADDR_W-1:0] sw_addr_i,
  input wire logic [DATA_W-1:0] sw_wdata_i,
  input wire logic sw_wr_i,
  input wire logic sw_rd_i,
  output logic [DATA_W-1:0] sw_rdata_o,
  apm_if.host link
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  apm_host_state_e state_q;
  apm_host_state_e state_d;
  logic [DATA_W-1:0] cfg_q;
  logic [DATA_W-1:0] rdbk_q;
  logic lp_refused_q;
  logic stop_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] sw_rdata_q;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  wire idle = (state_q == APM_H_IDLE);
  wire cmd_wr = sw_wr_i & (sw_addr_i == HOST_CMD_ADDR) & idle;
  wire go_start = cmd_wr & sw_wdata_i[CMD_START_BIT];
  wire go_stop = cmd_wr & ~sw_wdata_i[CMD_START_BIT] & sw_wdata_i[CMD_STOP_BIT];
  wire [RATE_CODE_W-1:0] cfg_code = cfg_q[RATE_CODE_LSB +: RATE_CODE_W];
  wire cfg_lp = cfg_q[LOW_POWER_BIT];
  wire lp_ok = (cfg_code >= LP_MIN_CODE) && (cfg_code <= LP_MAX_CODE);
  wire lp_use = cfg_lp & lp_ok;
  wire [DATA_W-1:0] rate_word = {3'h0, lp_use, cfg_code};
  wire [DATA_W-1:0] stat_word = {5'h00, lp_refused_q, rdbk_q[MEASURE_BIT], ~idle};
  wire [DATA_W-1:0] sw_mux =
    (sw_addr_i == HOST_CFG_ADDR) ? cfg_q :
    (sw_addr_i == HOST_STAT_ADDR) ? stat_word :
    (sw_addr_i == HOST_RDBK_ADDR) ? rdbk_q :
    8'h00;

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      APM_H_IDLE: begin
        if (go_start) begin
          state_d = APM_H_WR_RATE;
        end else if (go_stop) begin
          state_d = APM_H_WR_PWR;
        end
      end
      APM_H_WR_RATE: begin
        state_d = APM_H_WR_PWR;
      end
      APM_H_WR_PWR: begin
        state_d = APM_H_RD_PWR;
      end
      APM_H_RD_PWR: begin
        state_d = APM_H_RD_WAIT;
      end
      APM_H_RD_WAIT: begin
        state_d = APM_H_IDLE;
      end
      default: begin
        state_d = APM_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= APM_H_IDLE;
      cfg_q <= HOST_CFG_RESET;
      rdbk_q <= 8'h00;
      lp_refused_q <= 1'b0;
      stop_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      sw_rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      sw_rdata_q <= sw_rd_i ? sw_mux : 8'h00;
      if (sw_wr_i && sw_addr_i == HOST_CFG_ADDR && idle) begin
        cfg_q <= sw_wdata_i & RATE_REG_MASK;
      end
      if (go_start) begin
        stop_q <= 1'b0;
        lp_refused_q <= cfg_lp & ~lp_ok;
        addr_q <= RATE_REG_ADDR;
        wdata_q <= rate_word;
      end else if (go_stop) begin
        stop_q <= 1'b1;
        addr_q <= PWR_REG_ADDR;
        wdata_q <= PWR_STANDBY_CMD;
      end else if (state_q == APM_H_WR_RATE) begin
        addr_q <= PWR_REG_ADDR;
        wdata_q <= stop_q ? PWR_STANDBY_CMD : PWR_MEASURE_CMD;
      end else if (state_q == APM_H_WR_PWR) begin
        wdata_q <= 8'h00;
      end
      if (state_q == APM_H_RD_WAIT) begin
        rdbk_q <= link.rdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign link.wr = (state_q == APM_H_WR_RATE) | (state_q == APM_H_WR_PWR);
  assign link.rd = (state_q == APM_H_RD_PWR);
  assign sw_rdata_o = sw_rdata_q;

endmodule : apm_host

// File: sim/apm_monitor.sv
// checker for the host-device link and the device mode outputs
`timescale 1ns/10ps
module apm_monitor
  import apm_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic measuring_o,
  input wire logic low_power_o,
  input wire logic [RATE_CODE_W-1:0] rate_code_o,
  input wire logic sample_tick_o,
  input wire logic [SAMPLE_W-1:0] sample_o,
  input wire logic self_test_ok_o
);
  // ------------------------------------------------------------------
  // link and mode checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire logic pwr_wr = wr && addr == PWR_REG_ADDR;
  wire logic rate_wr = wr && addr == RATE_REG_ADDR;

  chk_mode_hold: assert property (!pwr_wr |=> $stable(measuring_o))
    else $error("mode changed without a command");
  chk_meas_enter: assert property (pwr_wr && wdata[MEASURE_BIT] |=> measuring_o)
    else $error("measure not entered");
  chk_meas_exit: assert property (pwr_wr && !wdata[MEASURE_BIT] |=> !measuring_o)
    else $error("standby not entered");
  chk_lp_write: assert property (rate_wr |=> low_power_o == $past(wdata[LOW_POWER_BIT]))
    else $error("low power bit not stored");
  chk_code_write: assert property (rate_wr |=> rate_code_o == $past(wdata[3:0]))
    else $error("rate code not stored");
  chk_lp_range: assert property (rate_wr && wdata[LOW_POWER_BIT] |->
    wdata[3:0] >= LP_MIN_CODE && wdata[3:0] <= LP_MAX_CODE)
    else $error("low power sent with unsuited code");
  chk_selftest_ok: assert property (self_test_ok_o == (measuring_o && !low_power_o))
    else $error("self test flag wrong");
  chk_read_idle: assert property (!rd |=> rdata == '0)
    else $error("read data outside read slot");
  chk_strobe_excl: assert property (!(wr && rd))
    else $error("write and read together");
  chk_tick_standby: assert property (!measuring_o |=> !sample_tick_o)
    else $error("sample tick in standby");
  chk_sample_keep: assert property (!measuring_o |=> $stable(sample_o))
    else $error("sample lost in standby");
  chk_cfg_first: assert property (pwr_wr && wdata[MEASURE_BIT] |-> $past(rate_wr))
    else $error("measure set before rate configured");
endmodule : apm_monitor

// File: sim/apm_tb.sv
// self-checking bench: host end and accelerometer end joined over the link
`timescale 1ns/10ps
module apm_tb
  import apm_pkg::*;
;
  localparam int unsigned BP = 4;
  logic clk_i, reset_i, sw_wr_i, sw_rd_i;
  logic [HOST_ADDR_W-1:0] sw_addr_i;
  logic [DATA_W-1:0] sw_wdata_i, sw_rdata_o;
  logic [SAMPLE_W-1:0] sample_i, sample_o;
  logic measuring_o, low_power_o, sample_tick_o, self_test_ok_o;
  logic [RATE_CODE_W-1:0] rate_code_o;
  int errors, comparisons;
  // behavioural model: mode, rate selection and sample store
  int m_meas, m_lp, m_code;
  logic [SAMPLE_W-1:0] m_samp [$];

  // ------------------------------------------------------------------
  // ends, link and checker
  // ------------------------------------------------------------------
  apm_if link ();
  apm_host apm_host_inst (.clk_i(clk_i), .reset_i(reset_i), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
    .sw_rdata_o(sw_rdata_o), .link(link));
  apm_device #(.BASE_PERIOD(BP), .CNT_W(32)) apm_device_inst (.clk_i(clk_i),
    .reset_i(reset_i), .link(link), .sample_i(sample_i), .measuring_o(measuring_o),
    .low_power_o(low_power_o), .rate_code_o(rate_code_o), .sample_tick_o(sample_tick_o),
    .sample_o(sample_o), .self_test_ok_o(self_test_ok_o));
  apm_monitor apm_monitor_inst (.clk_i(clk_i), .reset_i(reset_i), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .measuring_o(measuring_o), .low_power_o(low_power_o), .rate_code_o(rate_code_o),
    .sample_tick_o(sample_tick_o), .sample_o(sample_o), .self_test_ok_o(self_test_ok_o));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s exp %h got %h", name, exp, got);
    end
  endtask : chk

  task end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task sw_wr(input logic [HOST_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge clk_i);
    sw_wr_i <= 1'b0;
  endtask : sw_wr

  task sw_rd(input logic [HOST_ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge clk_i);
    sw_rd_i <= 1'b0;
    #1 d = sw_rdata_o;
  endtask : sw_rd

  task model_cmd(input bit start, input logic [DATA_W-1:0] cfg);
    if (start) begin
      m_code = int'(cfg[3:0]);
      m_lp = 0;
      if (cfg[LOW_POWER_BIT] && m_code >= int'(LP_MIN_CODE) &&
          m_code <= int'(LP_MAX_CODE)) begin
        m_lp = 1;
      end
    end
    m_meas = start ? 1 : 0;
  endtask : model_cmd

  task wait_idle;
    logic [DATA_W-1:0] s;
    int n;
    n = 0;
    s = 8'h01;
    while (s[STAT_BUSY_BIT] !== 1'b0 && n < 20) begin
      sw_rd(HOST_STAT_ADDR, s);
      n++;
    end
    if (s[STAT_BUSY_BIT] !== 1'b0) begin
      errors++;
      $display("mismatch busy exp 0 got 1");
      end_sim;
    end
  endtask : wait_idle

  task wait_tick(input int lim, output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (sample_tick_o !== 1'b1 && n < lim);
    if (sample_tick_o !== 1'b1) begin
      errors++;
      $display("mismatch tick exp 1 got 0");
      end_sim;
    end
  endtask : wait_tick

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [DATA_W-1:0] v;
    logic [DATA_W-1:0] cfg;
    logic [SAMPLE_W-1:0] sv;
    logic lp;
    int unsigned per;
    int n;
    {sw_addr_i, sw_wdata_i, sw_wr_i, sw_rd_i, sample_i} = '0;
    reset_i = 1'b1;
    errors = 0;
    comparisons = 0;
    m_meas = 0;
    m_lp = int'(RATE_REG_RESET[LOW_POWER_BIT]);
    m_code = int'(RATE_REG_RESET[3:0]);
    m_samp.push_back('0);
    void'($urandom(21));
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1 chk("measuring", 16'(m_meas), measuring_o);
    chk("rate_code", 16'(m_code), rate_code_o);
    chk("low_power", 16'(m_lp), low_power_o);
    chk("sample", m_samp[$], sample_o);
    sw_rd(HOST_RDBK_ADDR, v);
    chk("readback", PWR_REG_RESET, v);
    for (int c = 0; c < 16; c++) begin
      lp = 1'($urandom);
      cfg = {3'($urandom), lp, c[3:0]};
      per = BP << (15 - c);
      @(posedge clk_i);
      sample_i <= 16'($urandom);
      sw_wr(HOST_CFG_ADDR, cfg);
      sw_wr(HOST_CMD_ADDR, {6'h00, 1'($urandom), 1'b1});
      model_cmd(1'b1, cfg);
      // a config write while the host is busy must be ignored
      sw_wr(HOST_CFG_ADDR, ~cfg);
      wait_idle;
      sv = sample_i;
      chk("measuring", 16'(m_meas), measuring_o);
      chk("rate_code", 16'(m_code), rate_code_o);
      chk("low_power", 16'(m_lp), low_power_o);
      chk("self_test_ok", m_meas != 0 && m_lp == 0, self_test_ok_o);
      sw_rd(HOST_CFG_ADDR, v);
      chk("cfg", cfg & RATE_REG_MASK, v);
      sw_rd(HOST_STAT_ADDR, v);
      chk("lp_refused", lp && m_lp == 0, v[STAT_LPREF_BIT]);
      chk("stat_meas", 16'(m_meas), v[STAT_MEAS_BIT]);
      sw_rd(HOST_RDBK_ADDR, v);
      chk("readback", PWR_MEASURE_CMD, v);
      if (c >= 11) begin
        m_samp.push_back(sv);
        wait_tick(2 * per + 8, n);
        wait_tick(per + 8, n);
        chk("period", per[15:0], n[15:0]);
        chk("sample", m_samp[$], sample_o);
      end
      sw_wr(HOST_CMD_ADDR, 8'h02);
      model_cmd(1'b0, cfg);
      wait_idle;
      chk("measuring", 16'(m_meas), measuring_o);
      chk("self_test_ok", m_meas != 0 && m_lp == 0, self_test_ok_o);
      sw_rd(HOST_RDBK_ADDR, v);
      chk("readback", PWR_STANDBY_CMD, v);
      if (c >= 11) begin
        @(posedge clk_i);
        sample_i <= ~sv;
        repeat (per + 8) @(posedge clk_i);
        #1 chk("sample_held", m_samp[$], sample_o);
      end
    end
    end_sim;
  end
endmodule : apm_tb
